// ---- include/lbi_params.svh ----
// Purpose: constants of the local bus interface unit
// Assumes: included by its bare name from package and design files
// Notes: definitions only
`ifndef LBI_PARAMS_SVH
`define LBI_PARAMS_SVH

// prefetch queue depth in bytes
`define LBI_QUEUE_DEPTH 4
// clocks after reset release before the strap is taken
`define LBI_STRAP_SETTLE 2'h2
// type byte times four: shift by two
`define LBI_VEC_SHIFT 2'h2
// first prefetch address after reset
`define LBI_FETCH_RESET 16'hfff0
// coded cycle status, active low encoding
`define LBI_ST_INTERRUPT_ACK_STROBE_N 3'h0
`define LBI_ST_IORD 3'h1
`define LBI_ST_IOWR 3'h2
`define LBI_ST_HALT 3'h3
`define LBI_ST_CODE 3'h4
`define LBI_ST_MEMRD 3'h5
`define LBI_ST_MEMWR 3'h6
`define LBI_ST_PASSIVE 3'h7
// control pins at reset: strobes idle, passive status
`define LBI_CTRL_RESET 11'h3bf
// synchroniser reset: strap high, ready low, test high, hold low, data low
`define LBI_SYNC_RESET 12'ha00

`endif

// ---- include/lbi_pkg.sv ----
// Purpose: types of the local bus interface unit
// Assumes: nothing beyond the params header
// Notes: numbers live in the params header
`include "lbi_params.svh"

package lbi_pkg;

  typedef enum logic [2:0] {
    CYC_CODE,
    CYC_MEMRD,
    CYC_IORD,
    CYC_MEMWR,
    CYC_IOWR,
    CYC_INTERRUPT_ACK_STROBE_N,
    CYC_HALT
  } lbi_cycle_type;

  typedef enum logic [3:0] {
    S_IDLE,
    S_HDLY,
    S_T1,
    S_T2,
    S_T3,
    S_TW,
    S_T4,
    S_HALTED,
    S_HOLD
  } lbi_state_type;

  typedef struct packed {
    lbi_cycle_type cyc;
    logic word;
    logic [15:0] addr;
    logic [15:0] data;
  } lbi_req_type;

  typedef struct packed {
    logic ale;
    logic readStrobeN;
    logic writeStrobeN;
    logic interruptAckStrobeN;
    logic memIoSelect;
    logic transceiverDirection;
    logic transceiverEnableN;
    logic minModeStatusZeroN;
    logic [2:0] cycleStatus;
  } lbi_ctrl_type;

endpackage

// ---- rtl/lbi_sync2.sv ----
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous levels
// Notes: first stage feeds only the second stage
module lbi_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk, // clock
  input wire logic rstn, // async reset
  input wire logic [W-1:0] asyncIn, // raw pin levels
  output logic [W-1:0] syncOut // synchronised levels
);
  logic [W-1:0] stage1Reg;
  logic [W-1:0] stage2Reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage1Reg <= RST_VAL;
      stage2Reg <= RST_VAL;
    end else begin
      stage1Reg <= asyncIn;
      stage2Reg <= stage1Reg;
    end
  end

  assign syncOut = stage2Reg;
endmodule

// ---- rtl/lbi_prefetch_queue.sv ----
// Purpose: byte-wide instruction prefetch queue
// Assumes: the writer never pushes into a full queue
// Notes: shift register, head always in slot zero
`include "lbi_params.svh"

module lbi_prefetch_queue
  import lbi_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rstn, // async reset
  input wire logic flush, // drop all bytes
  input wire logic pushValid, // byte arrives
  input wire logic [7:0] pushByte, // arriving byte
  input wire logic popReady, // consumer takes head
  output logic headValid, // head slot holds a byte
  output logic [7:0] headByte, // head byte
  output logic [`LBI_QUEUE_DEPTH-1:0] fill // valid bit per slot
);
  localparam int D = `LBI_QUEUE_DEPTH;

  logic [D-1:0] vldReg;
  logic [D-1:0][7:0] byteReg;
  wire pop = popReady && vldReg[0];
  wire [D:0] vldExt = {1'b0, vldReg};
  wire [D:0][7:0] byteExt = {8'h00, byteReg};
  wire [D-1:0] shV;
  wire [D:0] shPrev = {shV, 1'b1};

  genvar i;
  for (i = 0; i < D; i++) begin : g_slot
    wire [7:0] shB = pop ? byteExt[i + 1] : byteReg[i];
    // push lands in the first empty slot after the shift
    wire load = pushValid && !shV[i] && shPrev[i];
    assign shV[i] = pop ? vldExt[i + 1] : vldReg[i];
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        vldReg[i] <= 1'b0;
        byteReg[i] <= 8'h00;
      end else if (flush) begin
        vldReg[i] <= 1'b0;
      end else begin
        vldReg[i] <= shV[i] || load;
        byteReg[i] <= load ? pushByte : shB;
      end
    end
  end

  assign headValid = vldReg[0];
  assign headByte = byteReg[0];
  assign fill = vldReg;
endmodule

// ---- rtl/lbi_bus_unit.sv ----
// Purpose: local bus interface unit, byte-wide multiplexed bus cycles
// Assumes: one clock per T state; two-way pins resolved outside from enables
// Notes: strap taken once after reset release; every pin output registered

`include "lbi_params.svh"

module lbi_bus_unit (
  input wire logic clk, // 40 MHz clock
  input wire logic rstn, // async reset
  input wire logic minMaxConfigStrap, // strap pin, high is minimum mode
  input wire logic readyPin, // ready pin
  input wire logic testNPin, // test pin, active low
  input wire logic holdReqPin, // local bus request pin
  input wire logic [7:0] muxedAddrDataLowIn, // muxed low lines, level seen
  output logic [7:0] muxedAddrDataLowOut, // muxed low lines, driven value
  output logic muxedAddrDataLowOeN, // low while driving muxed lines
  output logic [7:0] upperAddressLines, // address bits 15..8
  output logic upperAddressOeN, // low while driving upper address
  output lbi_pkg::lbi_ctrl_type ctrlPins, // strobes and status pins
  output logic ctrlOeN, // low while driving control pins
  output logic holdAck, // bus handed to another master
  input wire lbi_pkg::lbi_req_type req, // core bus request
  input wire logic reqValid, // core request present
  output logic reqTaken, // pulse, request accepted
  output logic respValid, // pulse, transfer finished
  output logic [15:0] respData, // read data
  output logic [9:0] vectorPtr, // vector table pointer
  input wire logic waitExec, // wait instruction executing
  output logic waitDone, // test seen low during wait
  input wire logic wakeHalt, // leave halt
  input wire logic flushValid, // restart prefetch
  input wire logic [15:0] flushAddr, // new prefetch address
  input wire logic qPop, // core takes queue head
  output logic qValid, // queue head valid
  output logic [7:0] qByte, // queue head byte
  output logic minMode // strap value in use
);
  import lbi_pkg::*;

  function automatic logic [2:0] statusCode(input lbi_cycle_type c);
    case (c)
      CYC_CODE: statusCode = `LBI_ST_CODE;
      CYC_MEMRD: statusCode = `LBI_ST_MEMRD;
      CYC_IORD: statusCode = `LBI_ST_IORD;
      CYC_MEMWR: statusCode = `LBI_ST_MEMWR;
      CYC_IOWR: statusCode = `LBI_ST_IOWR;
      CYC_INTERRUPT_ACK_STROBE_N: statusCode = `LBI_ST_INTERRUPT_ACK_STROBE_N;
      CYC_HALT: statusCode = `LBI_ST_HALT;
      default: statusCode = `LBI_ST_PASSIVE;
    endcase
  endfunction

  function automatic logic isReadCycle(input lbi_cycle_type c);
    isReadCycle = (c == CYC_CODE) || (c == CYC_MEMRD) || (c == CYC_IORD);
  endfunction

  lbi_state_type stateReg, stateNext;
  lbi_req_type curReg, curNext;
  logic byteHiReg, byteHiNext;
  logic intaSecondReg, intaSecondNext;
  logic isFetchReg, isFetchNext;
  logic haltReissueReg, haltReissueNext;
  logic takeReq;
  logic issueFetch;
  logic fetchDropReg;
  logic [15:0] fetchAddrReg;
  logic startedReg;
  logic [1:0] settleCntReg;
  logic capDueReg, capFetchReg, capLastReg, capIntaReg, capWordReg;
  logic [7:0] lowByteReg;
  lbi_ctrl_type ctrlNext;
  logic [7:0] adOutNext;
  logic [11:0] syncVec;
  logic [`LBI_QUEUE_DEPTH-1:0] qFill;

  lbi_sync2 #(
    .W(12),
    .RST_VAL(`LBI_SYNC_RESET)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .asyncIn({minMaxConfigStrap, readyPin, testNPin, holdReqPin, muxedAddrDataLowIn}),
    .syncOut(syncVec)
  );

  wire strapSync = syncVec[11];
  wire readySync = syncVec[10];
  wire testNSync = syncVec[9];
  wire holdSync = syncVec[8];
  wire [7:0] adSync = syncVec[7:0];

  // current cycle decode
  wire inCycle = stateReg inside {S_HDLY, S_T1, S_T2, S_T3, S_TW, S_T4};
  wire curRead = isReadCycle(curReg.cyc);
  wire curWrite = curReg.cyc inside {CYC_MEMWR, CYC_IOWR};
  wire curLast = !curReg.word || byteHiReg;
  wire fetchPending = capDueReg && capFetchReg;
  wire fetchInCycle = isFetchReg && inCycle;
  // one fetch in flight at most, so one free slot is enough
  wire fetchRoom = !qFill[`LBI_QUEUE_DEPTH-1] && !fetchPending && !flushValid;
  wire pushFetch = fetchPending && !fetchDropReg && !flushValid;
  wire endT4 = stateReg == S_T4;
  wire capNow = endT4 && (curRead || (curReg.cyc == CYC_INTERRUPT_ACK_STROBE_N && intaSecondReg));

  always_comb begin
    stateNext = stateReg;
    curNext = curReg;
    byteHiNext = byteHiReg;
    intaSecondNext = intaSecondReg;
    isFetchNext = isFetchReg;
    haltReissueNext = haltReissueReg;
    takeReq = 1'b0;
    issueFetch = 1'b0;
    case (stateReg)
      S_IDLE: begin
        if (!startedReg) begin
          stateNext = S_IDLE;
        end else if (holdSync) begin
          stateNext = S_HOLD;
        end else if (reqValid) begin
          takeReq = 1'b1;
          curNext = req;
          byteHiNext = 1'b0;
          intaSecondNext = 1'b0;
          isFetchNext = 1'b0;
          stateNext = (req.cyc == CYC_HALT && minMode) ? S_HDLY : S_T1;
        end else if (fetchRoom) begin
          issueFetch = 1'b1;
          curNext.cyc = CYC_CODE;
          curNext.word = 1'b0;
          curNext.addr = fetchAddrReg;
          curNext.data = 16'h0000;
          byteHiNext = 1'b0;
          intaSecondNext = 1'b0;
          isFetchNext = 1'b1;
          stateNext = S_T1;
        end
      end
      S_HDLY: begin
        stateNext = S_T1;
      end
      S_T1: begin
        stateNext = (curReg.cyc == CYC_HALT) ? S_HALTED : S_T2;
      end
      S_T2: begin
        stateNext = S_T3;
      end
      S_T3, S_TW: begin
        stateNext = readySync ? S_T4 : S_TW;
      end
      S_T4: begin
        if (curReg.word && !byteHiReg) begin
          byteHiNext = 1'b1;
          stateNext = S_T1;
        end else if (curReg.cyc == CYC_INTERRUPT_ACK_STROBE_N && !intaSecondReg) begin
          intaSecondNext = 1'b1;
          stateNext = S_T1;
        end else begin
          stateNext = S_IDLE;
        end
      end
      S_HALTED: begin
        if (holdSync) begin
          haltReissueNext = 1'b1;
          stateNext = S_HOLD;
        end else if (wakeHalt) begin
          stateNext = S_IDLE;
        end
      end
      S_HOLD: begin
        if (!holdSync) begin
          haltReissueNext = 1'b0;
          if (haltReissueReg) begin
            stateNext = minMode ? S_HDLY : S_T1;
          end else begin
            stateNext = S_IDLE;
          end
        end
      end
      default: begin
        stateNext = S_IDLE;
      end
    endcase
  end

  // pin values follow the state being entered
  wire nT1 = stateNext == S_T1;
  wire nStrobe = stateNext inside {S_T2, S_T3, S_TW};
  wire nData = nStrobe || stateNext == S_T4;
  wire nActive = nT1 || nData || stateNext == S_HDLY;
  wire nFloat = stateNext == S_HOLD;
  wire [2:0] nCode = statusCode(curNext.cyc);
  wire nRead = isReadCycle(curNext.cyc);
  wire nWrite = curNext.cyc inside {CYC_MEMWR, CYC_IOWR};
  wire nInta = curNext.cyc == CYC_INTERRUPT_ACK_STROBE_N;
  wire nHalt = curNext.cyc == CYC_HALT;
  wire [15:0] nAddr = curNext.addr + {15'h0000, byteHiNext};
  wire [7:0] nWriteByte = byteHiNext ? curNext.data[15:8] : curNext.data[7:0];
  wire nDriveAddr = nT1 && !nInta;
  wire nDriveData = nWrite && nData;
  // reads and acknowledges release the low lines to bus-hold
  wire adOeNNext = !(nDriveAddr || nDriveData) || nFloat;
  wire [7:0] upperNext = nDriveAddr ? nAddr[15:8] : upperAddressLines;

  assign adOutNext = nDriveAddr ? nAddr[7:0] : (nDriveData ? nWriteByte : muxedAddrDataLowOut);

  always_comb begin
    ctrlNext = `LBI_CTRL_RESET;
    if (minMode) begin
      ctrlNext.ale = nT1;
      ctrlNext.readStrobeN = !(nRead && nStrobe);
      ctrlNext.writeStrobeN = !(nWrite && nStrobe);
      ctrlNext.interruptAckStrobeN = !(nInta && nStrobe);
      ctrlNext.memIoSelect = nActive ? !nCode[2] : ctrlPins.memIoSelect;
      ctrlNext.transceiverDirection = nActive ? nCode[1] : 1'b1;
      ctrlNext.transceiverEnableN = !(nData && !nHalt);
      ctrlNext.minModeStatusZeroN = nActive ? nCode[0] : 1'b1;
    end else begin
      // bus controller decodes status and makes the strobes
      ctrlNext.cycleStatus = (nT1 || stateNext == S_T2) ? nCode : `LBI_ST_PASSIVE;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrlPins <= `LBI_CTRL_RESET;
      muxedAddrDataLowOut <= 8'h00;
      muxedAddrDataLowOeN <= 1'b1;
      upperAddressLines <= 8'h00;
      upperAddressOeN <= 1'b1;
      ctrlOeN <= 1'b1;
      holdAck <= 1'b0;
    end else begin
      ctrlPins <= ctrlNext;
      muxedAddrDataLowOut <= adOutNext;
      muxedAddrDataLowOeN <= adOeNNext;
      upperAddressLines <= upperNext;
      upperAddressOeN <= nFloat;
      ctrlOeN <= nFloat;
      holdAck <= nFloat;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stateReg <= S_IDLE;
      curReg <= '0;
      byteHiReg <= 1'b0;
      intaSecondReg <= 1'b0;
      isFetchReg <= 1'b0;
      haltReissueReg <= 1'b0;
    end else begin
      stateReg <= stateNext;
      curReg <= curNext;
      byteHiReg <= byteHiNext;
      intaSecondReg <= intaSecondNext;
      isFetchReg <= isFetchNext;
      haltReissueReg <= haltReissueNext;
    end
  end

  // strap caught once, after the synchroniser has settled
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      settleCntReg <= 2'h0;
      startedReg <= 1'b0;
      minMode <= 1'b1;
    end else if (!startedReg) begin
      settleCntReg <= settleCntReg + 2'h1;
      if (settleCntReg == `LBI_STRAP_SETTLE) begin
        startedReg <= 1'b1;
        minMode <= strapSync;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fetchAddrReg <= `LBI_FETCH_RESET;
      fetchDropReg <= 1'b0;
    end else begin
      if (flushValid) begin
        fetchAddrReg <= flushAddr;
      end else if (issueFetch) begin
        fetchAddrReg <= fetchAddrReg + 16'h0001;
      end
      if (fetchPending) begin
        fetchDropReg <= 1'b0;
      end else if (flushValid && fetchInCycle) begin
        fetchDropReg <= 1'b1;
      end
    end
  end

  // read data leaves the synchroniser one clock after T4
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      capDueReg <= 1'b0;
      capFetchReg <= 1'b0;
      capLastReg <= 1'b0;
      capIntaReg <= 1'b0;
      capWordReg <= 1'b0;
    end else begin
      capDueReg <= capNow;
      capFetchReg <= isFetchReg;
      capLastReg <= curLast;
      capIntaReg <= curReg.cyc == CYC_INTERRUPT_ACK_STROBE_N;
      capWordReg <= curReg.word;
    end
  end

  wire dataCap = capDueReg && !capFetchReg && !capIntaReg;
  wire writeDone = endT4 && curWrite && curLast;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reqTaken <= 1'b0;
      respValid <= 1'b0;
      respData <= 16'h0000;
      vectorPtr <= 10'h000;
      lowByteReg <= 8'h00;
      waitDone <= 1'b0;
    end else begin
      reqTaken <= takeReq;
      respValid <= writeDone || (dataCap && capLastReg) || (capDueReg && capIntaReg);
      waitDone <= waitExec && !testNSync;
      if (dataCap && !capLastReg) begin
        lowByteReg <= adSync;
      end
      if (dataCap && capLastReg) begin
        respData <= capWordReg ? {adSync, lowByteReg} : {8'h00, adSync};
      end
      if (capDueReg && capIntaReg) begin
        vectorPtr <= {2'b00, adSync} << `LBI_VEC_SHIFT;
      end
    end
  end

  lbi_prefetch_queue u_queue (
    .clk(clk),
    .rstn(rstn),
    .flush(flushValid),
    .pushValid(pushFetch),
    .pushByte(adSync),
    .popReady(qPop),
    .headValid(qValid),
    .headByte(qByte),
    .fill(qFill)
  );
endmodule

// ---- tb/lbi_bus_unit_properties.sv ----
// Purpose: pin relations of the local bus interface unit
// Assumes: sees only the top module ports
// Notes: bound to every lbi_bus_unit
module lbi_bus_props (
  input wire logic clk, // clock
  input wire logic rstn, // async reset
  input wire logic readyPin, // ready pin
  input wire logic testNPin, // test pin
  input wire logic muxedAddrDataLowOeN, // low lines enable
  input wire logic [7:0] upperAddressLines, // address 15..8
  input wire logic upperAddressOeN, // upper enable
  input wire lbi_pkg::lbi_ctrl_type ctrlPins, // strobes and status
  input wire logic ctrlOeN, // control enable
  input wire logic holdAck, // bus released
  input wire logic waitExec, // wait executing
  input wire logic waitDone, // test seen low
  input wire logic minMode // strap in use
);
  import lbi_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_wr_data; !ctrlPins.writeStrobeN |-> !muxedAddrDataLowOeN; endproperty
  a_wr_data: assert property (p_wr_data) else $error("write strobe without data");
  property p_rd_float; !ctrlPins.readStrobeN |-> muxedAddrDataLowOeN; endproperty
  a_rd_float: assert property (p_rd_float) else $error("lines driven in read");
  property p_ack;
    !ctrlPins.interruptAckStrobeN |-> muxedAddrDataLowOeN && ctrlPins.readStrobeN;
  endproperty
  a_ack: assert property (p_ack) else $error("bad acknowledge strobe");
  property p_ale; $rose(ctrlPins.ale) |=> !ctrlPins.ale; endproperty
  a_ale: assert property (p_ale) else $error("latch strobe too long");
  property p_upper; $fell(ctrlPins.ale) |-> $stable(upperAddressLines)[*3]; endproperty
  a_upper: assert property (p_upper) else $error("upper address moved");
  property p_max;
    !minMode |-> ctrlPins.readStrobeN && ctrlPins.writeStrobeN && !ctrlPins.ale;
  endproperty
  a_max: assert property (p_max) else $error("strobe in coded mode");
  property p_dir;
    minMode && !ctrlPins.readStrobeN |->
      !ctrlPins.transceiverDirection && !ctrlPins.transceiverEnableN;
  endproperty
  a_dir: assert property (p_dir) else $error("transceiver wrong in read");
  property p_hold; holdAck |-> ctrlOeN && upperAddressOeN && muxedAddrDataLowOeN; endproperty
  a_hold: assert property (p_hold) else $error("driver active in hold");
  property p_test; testNPin[*5] |-> !waitDone; endproperty
  a_test: assert property (p_test) else $error("wait ended with test high");
  property p_wexec; waitDone |-> $past(waitExec); endproperty
  a_wexec: assert property (p_wexec) else $error("wait done without wait");
  property p_ready;
    !readyPin[*5] ##0 !ctrlPins.readStrobeN |=> !ctrlPins.readStrobeN;
  endproperty
  a_ready: assert property (p_ready) else $error("read ended while not ready");
  c_read: cover property ($fell(ctrlPins.readStrobeN));
  c_write: cover property ($fell(ctrlPins.writeStrobeN));
  c_ack: cover property ($fell(ctrlPins.interruptAckStrobeN));
  c_hold: cover property ($rose(holdAck));
endmodule

bind lbi_bus_unit lbi_bus_props u_lbi_bus_props (.clk, .rstn, .readyPin, .testNPin,
  .muxedAddrDataLowOeN, .upperAddressLines, .upperAddressOeN, .ctrlPins, .ctrlOeN,
  .holdAck, .waitExec, .waitDone, .minMode);

// ---- tb/lbi_bus_model.sv ----
// Purpose: memory, io and interrupt controller on the local bus
// Assumes: minimum mode strobes
// Notes: byte index is low address xor high address
module lbi_bus_model (
  input wire logic clk, // clock
  input wire lbi_pkg::lbi_ctrl_type ctrlPins, // strobes seen
  input wire logic [7:0] busLevel, // resolved low lines
  input wire logic [7:0] upperAddressLines, // address 15..8
  input wire logic [3:0] waits, // not ready clocks per strobe
  input wire logic [7:0] typeByte, // interrupt type
  output logic readyPin, // ready
  output logic drvEn, // model drives low lines
  output logic [7:0] drvByte // driven value
);
  import lbi_pkg::*;
  logic [7:0] mem [256];
  logic [7:0] idx = 8'h00;
  logic [7:0] val;
  logic [3:0] cnt = 4'h0;
  logic ioSel = 1'b0;
  wire strobeN = ctrlPins.readStrobeN & ctrlPins.writeStrobeN & ctrlPins.interruptAckStrobeN;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end
  always @(negedge clk) begin
    if (ctrlPins.ale) begin
      idx <= busLevel ^ upperAddressLines;
      ioSel <= ctrlPins.memIoSelect;
    end
    if (!ctrlPins.writeStrobeN && !ioSel) begin
      mem[idx] <= busLevel;
    end
    if (strobeN) cnt <= waits;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  end
  assign readyPin = cnt == 4'h0;
  assign drvEn = !ctrlPins.readStrobeN || !ctrlPins.interruptAckStrobeN;
  assign val = !ctrlPins.interruptAckStrobeN ? typeByte : ioSel ? idx ^ 8'ha5 : mem[idx];
  // garbage until ready
  assign drvByte = readyPin ? val : ~val;
endmodule

// ---- tb/test_cpu_local_bus_interface.sv ----
// Purpose: self-checking bench of the local bus interface unit
// Assumes: inputs change on the falling edge
// Notes: low lines resolved here, bus-hold keeps the last level
`include "lbi_params.svh"
module test_cpu_local_bus_interface;
  timeunit 1ns;
  timeprecision 1ps;
  import lbi_pkg::*;
  typedef struct packed {
    logic [2:0] st;
    logic [1:0] kind;
    logic [15:0] val;
  } lbi_exp_type;
  logic clk = 1'b0, rstn = 1'b0, strap = 1'b1, testN = 1'b1, holdReq = 1'b0;
  logic reqValid = 1'b0, waitExec = 1'b0, wakeHalt = 1'b0, qPop = 1'b0, prevAle;
  logic adOeN, upOeN, ctrlOeN, holdAck, reqTaken, respValid, waitDone, qValid, minMode;
  logic readyPin, drvEn, flushValid = 1'b0;
  logic [7:0] adOut, upper, qByte, drvByte, busLevel = 8'h00, typeByte = 8'h00;
  logic [15:0] respData, a, lfsr = 16'h0006, flushAddr = 16'h0000;
  logic [9:0] vectorPtr;
  logic [3:0] waits = 4'h0;
  logic [2:0] lastSt;
  logic [7:0] shadow [256];
  logic [2:0] stOf [7];
  lbi_ctrl_type ctrl;
  lbi_req_type req = '0;
  lbi_exp_type expQ[$];
  lbi_exp_type e;
  int numErrors = 0, comparisons = 0, cyc = 0, tStart = 0, lat = 0, aleRises = 0, n, latW;

  lbi_bus_unit u_lbi_bus_unit (.clk, .rstn, .minMaxConfigStrap(strap), .readyPin,
    .testNPin(testN), .holdReqPin(holdReq), .muxedAddrDataLowIn(busLevel),
    .muxedAddrDataLowOut(adOut), .muxedAddrDataLowOeN(adOeN), .upperAddressLines(upper),
    .upperAddressOeN(upOeN), .ctrlPins(ctrl), .ctrlOeN, .holdAck, .req, .reqValid,
    .reqTaken, .respValid, .respData, .vectorPtr, .waitExec, .waitDone, .wakeHalt,
    .flushValid, .flushAddr, .qPop, .qValid, .qByte, .minMode);
  lbi_bus_model u_lbi_bus_model (.clk, .ctrlPins(ctrl), .busLevel,
    .upperAddressLines(upper), .waits, .typeByte, .readyPin, .drvEn, .drvByte);

  always #12.5 clk = ~clk;
  always @(adOut, adOeN, drvEn, drvByte) begin
    if (!adOeN) busLevel = adOut;
    else if (drvEn) busLevel = drvByte;
  end

  function automatic logic [15:0] nextRand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] memAt(input logic [15:0] x);
    return shadow[x[7:0] ^ x[15:8]];
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      numErrors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic testDone();
    $display("comparisons %0d mismatches %0d", comparisons, numErrors);
    if (numErrors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic hang(input string what);
    check(what, 16'h0000, 16'h0001);
    testDone();
  endtask

  // watcher: status capture and response compare
  always @(negedge clk) begin
    cyc++;
    if (ctrl.ale === 1'b1 && prevAle !== 1'b1) aleRises++;
    prevAle = ctrl.ale;
    if (strap && ctrl.ale) lastSt = {~ctrl.memIoSelect, ctrl.transceiverDirection,
      ctrl.minModeStatusZeroN};
    else if (!strap && ctrl.cycleStatus != `LBI_ST_PASSIVE) lastSt = ctrl.cycleStatus;
    if (reqTaken === 1'b1) tStart = cyc;
    if (respValid === 1'b1) begin
      lat = cyc - tStart;
      e = expQ.size() != 0 ? expQ.pop_front() : '1;
      check("cycle status", 16'(lastSt), 16'(e.st));
      if (e.kind == 2'h1) check("read data", respData, e.val);
      if (e.kind == 2'h2) check("vector pointer", {6'h00, vectorPtr}, e.val);
    end
  end

  task automatic issue(input lbi_cycle_type c, input logic w, input logic [15:0] ad);
    lbi_exp_type x;
    logic [15:0] a1;
    a1 = ad + 16'h0001;
    lfsr = nextRand(lfsr);
    req = '{cyc: c, word: w, addr: ad, data: lfsr};
    typeByte = lfsr[15:8];
    x = '{stOf[c], 2'h0, 16'h0000};
    if (strap === 1'b1) begin
      case (c)
        CYC_MEMRD: x = '{stOf[c], 2'h1, {w ? memAt(a1) : 8'h00, memAt(ad)}};
        CYC_IORD: x = '{stOf[c], 2'h1, {w ? memAt(a1) ^ 8'h00 : 8'h00, 8'h00}};
        CYC_INTERRUPT_ACK_STROBE_N: x = '{stOf[c], 2'h2, {6'h00, typeByte, 2'b00}};
        CYC_MEMWR: begin
          shadow[ad[7:0] ^ ad[15:8]] = lfsr[7:0];
          if (w) shadow[a1[7:0] ^ a1[15:8]] = lfsr[15:8];
        end
        default: x.kind = 2'h0;
      endcase
      if (c == CYC_IORD) x.val = {w ? a1[7:0] ^ a1[15:8] ^ 8'ha5 : 8'h00,
        ad[7:0] ^ ad[15:8] ^ 8'ha5};
    end
    if (c != CYC_HALT) expQ.push_back(x);
    reqValid = 1'b1;
    for (n = 0; n < 60 && reqTaken !== 1'b1; n++) @(negedge clk);
    reqValid = 1'b0;
    if (n == 60) hang("request taken");
    check("latch strobe at take", 16'(ctrl.ale), 16'(strap && c != CYC_HALT));
    @(negedge clk);
    if (c == CYC_HALT) begin
      check("delayed latch strobe", 16'(ctrl.ale), 16'(strap));
      repeat (4) @(negedge clk);
      check("halt status", 16'(lastSt), 16'(stOf[c]));
      wakeHalt = 1'b1;
      @(negedge clk);
      wakeHalt = 1'b0;
    end
    for (n = 0; n < 200 && expQ.size() != 0; n++) @(negedge clk);
    if (n == 200) hang("response");
    @(negedge clk);
  endtask

  initial begin
    for (int i = 0; i < 256; i++) begin
      shadow[i] = 8'(i) ^ 8'h5a;
    end
    stOf = '{`LBI_ST_CODE, `LBI_ST_MEMRD, `LBI_ST_IORD, `LBI_ST_MEMWR, `LBI_ST_IOWR,
      `LBI_ST_INTERRUPT_ACK_STROBE_N, `LBI_ST_HALT};
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (80) @(negedge clk);
    check("fetches to fill queue", 16'(aleRises), 16'h0004);
    check("code fetch status", 16'(lastSt), 16'(stOf[0]));
    for (int i = 0; i < 6; i++) begin
      check("queue head", {7'h00, qValid, qByte}, {8'h01, memAt(16'hfff0 + 16'(i))});
      qPop = 1'b1;
      @(negedge clk);
      qPop = 1'b0;
      repeat (12) @(negedge clk);
    end
    lfsr = nextRand(lfsr);
    flushAddr = lfsr;
    flushValid = 1'b1;
    @(negedge clk);
    flushValid = 1'b0;
    repeat (40) @(negedge clk);
    check("head after flush", {7'h00, qValid, qByte}, {8'h01, memAt(flushAddr)});
    $display("test prefetch done");
    repeat (40) @(negedge clk);
    waitExec = 1'b1;
    latW = aleRises;
    repeat (30) @(negedge clk);
    check("wait done, test high", 16'(waitDone), 16'h0000);
    check("fetches while waiting", 16'(aleRises - latW), 16'h0000);
    holdReq = 1'b1;
    for (n = 0; n < 20 && holdAck !== 1'b1; n++) @(negedge clk);
    if (n == 20) hang("hold granted");
    check("drivers floated", {13'h0000, ctrlOeN, upOeN, adOeN}, 16'h0007);
    holdReq = 1'b0;
    for (n = 0; n < 20 && holdAck !== 1'b0; n++) @(negedge clk);
    if (n == 20) hang("hold released");
    testN = 1'b0;
    for (n = 0; n < 20 && waitDone !== 1'b1; n++) @(negedge clk);
    if (n == 20) hang("wait ended");
    check("wait done, test low", 16'(waitDone), 16'h0001);
    waitExec = 1'b0;
    testN = 1'b1;
    $display("test wait and hold done");
    for (int i = 0; i < 6; i++) begin
      lfsr = nextRand(lfsr);
      a = lfsr;
      waits = i[0] ? 4'h6 : 4'h0;
      issue(CYC_MEMWR, 1'b1, a);
      issue(CYC_MEMRD, 1'b1, a);
      latW = lat;
      issue(CYC_MEMRD, 1'b0, a);
      if (!i[0]) check("word extra clocks", 16'(latW - lat), 16'h0004);
      issue(CYC_IOWR, 1'b0, a);
      issue(CYC_IORD, 1'b1, a);
      issue(CYC_INTERRUPT_ACK_STROBE_N, 1'b0, a);
    end
    issue(CYC_HALT, 1'b0, 16'h0000);
    $display("test minimum mode cycles done");
    rstn = 1'b0;
    strap = 1'b0;
    waits = 4'h0;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (80) @(negedge clk);
    check("strap low mode", 16'(minMode), 16'h0000);
    check("coded code fetch", 16'(lastSt), 16'(stOf[0]));
    for (int c = 1; c < 7; c++) begin
      issue(lbi_cycle_type'(c), 1'b0, lfsr);
    end
    $display("test coded status done");
    testDone();
  end
endmodule
